// [common/swb_pkg.sv]
// Package: sizes, access encodings and request/response carriers for the SRAM controller
package swb_pkg;

  localparam int SWB_DATA_W = 32;
  localparam int SWB_ADDR_W = 32;
  localparam int SWB_BYTES = 4;
  localparam int SWB_DEF_KBYTES = 32;
  localparam int SWB_HALF_LSB = 1;
  localparam int SWB_WORD_LSB = 2;

  typedef enum logic [1:0] {
    SWB_SZ_BYTE = 2'h0,
    SWB_SZ_HALF = 2'h1,
    SWB_SZ_WORD = 2'h2
  } swb_size_t;

  typedef struct packed {
    logic valid;
    logic write;
    swb_size_t size;
    logic [SWB_ADDR_W-1:0] addr;
    logic [SWB_DATA_W-1:0] wdata;
  } swb_req_t;

  typedef struct packed {
    logic valid;
    logic [SWB_DATA_W-1:0] rdata;
  } swb_rsp_t;

endpackage : swb_pkg

// [rtl/swb_sram_ctrl.sv]
// SRAM controller with single-entry write-back buffer
//
// Overview of operation
// - Byte, halfword, word reads and writes accepted.
// - Word access ignores address bits one, zero.
// - Halfword access ignores address bit zero.
// - Lowest byte address on lowest lane.
// - Write buffer keeps back-to-back writes unstalled.
// - Buffer holds last write address, data, size.
// - Buffered write committed when next write arrives.
// - Reset discards the pending buffered write.
// - Array capacity selectable: 8, 16, 32 kB.
`timescale 1ns/10ps
module swb_sram_ctrl
  import swb_pkg::*;
#(
  parameter int MEM_KBYTES = SWB_DEF_KBYTES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire swb_req_t req,
  output swb_rsp_t rsp
);

  localparam int WORDS = MEM_KBYTES * 256;
  localparam int IDX_W = $clog2(WORDS);

  // Byte-lane enables from size and low address bits
  function automatic logic [SWB_BYTES-1:0] lane_mask(swb_size_t sz, logic [1:0] lo);
    logic [SWB_BYTES-1:0] m;
    m = 4'h0;
    case (sz)
      SWB_SZ_BYTE: m = 4'h1 << lo;
      SWB_SZ_HALF: m = lo[SWB_HALF_LSB] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction : lane_mask

  // Place write data onto its lanes, replicated so any lane sees it
  function automatic logic [SWB_DATA_W-1:0] lane_data(swb_size_t sz, logic [31:0] d);
    logic [SWB_DATA_W-1:0] r;
    r = d;
    case (sz)
      SWB_SZ_BYTE: r = {4{d[7:0]}};
      SWB_SZ_HALF: r = {2{d[15:0]}};
      default: r = d;
    endcase
    return r;
  endfunction : lane_data

  function automatic logic [IDX_W-1:0] word_idx(logic [SWB_ADDR_W-1:0] a);
    return a[SWB_WORD_LSB +: IDX_W];
  endfunction : word_idx

  logic [SWB_DATA_W-1:0] arr_word;

  // Write-back buffer
  logic buf_valid;
  logic [IDX_W-1:0] buf_idx;
  logic [SWB_BYTES-1:0] buf_mask;
  logic [SWB_DATA_W-1:0] buf_data;
  logic next_buf_valid;
  logic [IDX_W-1:0] next_buf_idx;
  logic [SWB_BYTES-1:0] next_buf_mask;
  logic [SWB_DATA_W-1:0] next_buf_data;
  logic commit;

  // Read response
  swb_rsp_t next_rsp;

  logic req_wr;
  logic req_rd;
  logic [IDX_W-1:0] req_idx;
  logic [SWB_BYTES-1:0] req_mask;

  always_comb begin
    req_wr = req.valid & req.write;
    req_rd = req.valid & ~req.write;
    req_idx = word_idx(req.addr);
    req_mask = lane_mask(req.size, req.addr[1:0]);
    next_buf_valid = buf_valid;
    next_buf_idx = buf_idx;
    next_buf_mask = buf_mask;
    next_buf_data = buf_data;
    commit = 1'b0;
    if (req_wr) begin
      commit = buf_valid;
      next_buf_valid = 1'b1;
      next_buf_idx = req_idx;
      next_buf_mask = req_mask;
      next_buf_data = lane_data(req.size, req.wdata);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_valid <= 1'b0;
      buf_idx <= '0;
      buf_mask <= 4'h0;
      buf_data <= 32'h0;
    end else begin
      buf_valid <= next_buf_valid;
      buf_idx <= next_buf_idx;
      buf_mask <= next_buf_mask;
      buf_data <= next_buf_data;
    end
  end

  // Array commit of the displaced buffer entry; no reset so contents survive
  // Each lane owns its storage so every array has a single writer
  genvar gl;
  generate
    for (gl = 0; gl < SWB_BYTES; gl++) begin : g_lane
      logic [7:0] lane_mem [WORDS];
      always_ff @(posedge core_clk) begin
        if (!rst && commit && buf_mask[gl]) begin
          lane_mem[buf_idx] <= buf_data[gl*8 +: 8];
        end
      end
      assign arr_word[gl*8 +: 8] = lane_mem[req_idx];
    end
  endgenerate

  always_comb begin
    logic [SWB_DATA_W-1:0] word;
    word = arr_word;
    for (int i = 0; i < SWB_BYTES; i++) begin
      if (buf_valid && buf_idx == req_idx && buf_mask[i]) begin
        word[i*8 +: 8] = buf_data[i*8 +: 8];
      end
    end
    next_rsp.valid = req_rd;
    next_rsp.rdata = 32'h0;
    for (int i = 0; i < SWB_BYTES; i++) begin
      if (req_mask[i]) begin
        next_rsp.rdata[i*8 +: 8] = word[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  a_commit_on_write: assert property (@(posedge core_clk) disable iff (rst)
    commit |-> req_wr && buf_valid)
    else $error("array commit without a following write");

  a_buf_tracks_write: assert property (@(posedge core_clk) disable iff (rst)
    req_wr |=> buf_valid && buf_idx == $past(req_idx) && buf_mask == $past(req_mask))
    else $error("buffer did not capture last write");

  a_rd_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    req_rd |=> rsp.valid)
    else $error("read answer missing one cycle later");

  a_word_mask: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && req.size == SWB_SZ_WORD |-> req_mask == 4'hF)
    else $error("word access not full width");

  a_half_mask: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && req.size == SWB_SZ_HALF |-> (req_mask == 4'h3) != req.addr[1])
    else $error("halfword lanes wrong");

  a_byte_lane: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && req.size == SWB_SZ_BYTE |-> req_mask[req.addr[1:0]] && $onehot(req_mask))
    else $error("byte lane wrong");

  a_reset_clears_buf: assert property (@(posedge core_clk)
    rst |=> !buf_valid && !commit)
    else $error("buffer survived reset");

  a_first_write_no_commit: assert property (@(posedge core_clk) disable iff (rst)
    req_wr && !buf_valid |-> !commit ##1 buf_valid)
    else $error("first write committed instead of loading buffer");

  a_read_sees_buffer: assert property (@(posedge core_clk) disable iff (rst)
    req_rd && req.size == SWB_SZ_WORD && buf_valid && buf_idx == req_idx && buf_mask == 4'hF
    |=> rsp.rdata == $past(buf_data))
    else $error("read missed buffered data");

  a_rsp_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !req_rd |=> !rsp.valid)
    else $error("answer without a read");

  a_buf_retains: assert property (@(posedge core_clk) disable iff (rst)
    !req_wr |=> $stable(buf_data) && $stable(buf_idx) && $stable(buf_mask))
    else $error("buffer changed without a write");

endmodule : swb_sram_ctrl

// [tb/swb_core_model.sv]
// Core-side request driver for the SRAM controller
`timescale 1ns/10ps
module swb_core_model
  import swb_pkg::*;
(
  input wire logic core_clk,
  output swb_req_t req
);
  initial req = '0;
  // Holds one request up to its taking edge
  task put(input logic w, input swb_size_t s, input logic [31:0] a, input logic [31:0] d);
    req = '{1'b1, w, s, a, d};
    @(posedge core_clk);
    #1;
  endtask : put
  // Released data no longer shows the last value
  task idle();
    req.valid = 1'b0;
    req.wdata = ~req.wdata;
    @(posedge core_clk);
    #1;
  endtask : idle
endmodule : swb_core_model

// [tb/swb_sram_ctrl_tb_top.sv]
// Self-checking testbench of the SRAM controller
`timescale 1ns/10ps
module swb_sram_ctrl_tb_top
  import swb_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  swb_req_t req;
  swb_rsp_t rsp;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 core_clk = ~core_clk;
  swb_core_model u_core (.core_clk(core_clk), .req(req));
  swb_sram_ctrl #(.MEM_KBYTES(8)) u_dut (.core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp));
  task print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input swb_size_t s, input logic [31:0] a, input logic [31:0] d);
    u_core.put(1'b1, s, a, d);
    cmp({rsp.valid, 32'h0}, 33'h0);
  endtask : wr
  task rd(input swb_size_t s, input logic [31:0] a, input logic [31:0] e);
    u_core.put(1'b0, s, a, 32'h0);
    cmp({rsp.valid, rsp.rdata}, {1'b1, e});
  endtask : rd
  // A read presented during reset must get no answer
  task pulse_rst();
    rst = 1'b1;
    u_core.put(1'b0, SWB_SZ_WORD, 32'h10, 32'h0);
    cmp({rsp.valid, rsp.rdata}, 33'h0);
    rst = 1'b0;
  endtask : pulse_rst
  task t_lanes();
    wr(SWB_SZ_WORD, 32'h20, 32'h44332211);
    wr(SWB_SZ_HALF, 32'h33, 32'h0000BEEF);
    rd(SWB_SZ_BYTE, 32'h21, 32'h00002200);
    rd(SWB_SZ_HALF, 32'h23, 32'h44330000);
    rd(SWB_SZ_WORD, 32'h22, 32'h44332211);
    rd(SWB_SZ_HALF, 32'h32, 32'hBEEF0000);
    wr(SWB_SZ_BYTE, 32'h22, 32'h000000AB);
    rd(SWB_SZ_WORD, 32'h20, 32'h44AB2211);
    u_core.idle();
    $display("test lanes done");
  endtask : t_lanes
  task t_b2b();
    for (int i = 0; i < 4; i++) begin
      wr(SWB_SZ_WORD, 32'h50 + 4 * i, 32'hA0 + i);
    end
    for (int i = 0; i < 4; i++) begin
      rd(SWB_SZ_WORD, 32'h50 + 4 * i, 32'hA0 + i);
    end
    u_core.idle();
    $display("test back to back done");
  endtask : t_b2b
  task t_reset();
    wr(SWB_SZ_WORD, 32'h10, 32'h0000CAFE);
    wr(SWB_SZ_WORD, 32'h10, 32'h0000CAFE);
    wr(SWB_SZ_WORD, 32'h10, 32'h12345678);
    rd(SWB_SZ_WORD, 32'h10, 32'h12345678);
    u_core.idle();
    pulse_rst();
    rd(SWB_SZ_WORD, 32'h10, 32'h0000CAFE);
    wr(SWB_SZ_WORD, 32'h14, 32'h0000000A);
    rd(SWB_SZ_WORD, 32'h10, 32'h0000CAFE);
    rd(SWB_SZ_WORD, 32'h14, 32'h0000000A);
    u_core.idle();
    $display("test reset done");
  endtask : t_reset
  task t_survive();
    wr(SWB_SZ_WORD, 32'h18, 32'h0000BEAD);
    wr(SWB_SZ_WORD, 32'h18, 32'h0000BEAD);
    pulse_rst();
    rd(SWB_SZ_WORD, 32'h18, 32'h0000BEAD);
    rd(swb_size_t'(2'h3), 32'h1A, 32'h0000BEAD);
    wr(SWB_SZ_WORD, 32'h1C, 32'h00000777);
    wr(SWB_SZ_BYTE, 32'h40, 32'h00000000);
    pulse_rst();
    rd(SWB_SZ_WORD, 32'h1C, 32'h00000777);
    u_core.idle();
    $display("test survive done");
  endtask : t_survive
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_lanes();
    t_b2b();
    t_reset();
    t_survive();
    print_verdict();
  end
  initial begin
    #2000;
    mismatches++;
    print_verdict();
  end
endmodule : swb_sram_ctrl_tb_top
